// *** dv/cpu_bus_model.sv ***
/*
 Processor bus model: register accesses and interrupt acknowledge cycles.
 Assumes the 100 MHz core clock; drives its lines at the falling edge.
*/
`timescale 1ns/10ps
`include "sys_ctrl_consts.svh"
module cpu_bus_model (
    input wire logic core_clk_in,
    input wire logic [31:0] bus_data_in,
    input wire logic bus_data_oe_n_in,
    input wire logic bypass_req_in,
    output logic bus_sel_out,
    output logic bus_wr_out,
    output logic [1:0] bus_size_out,
    output logic [31:0] bus_addr_out,
    output logic iack_out,
    output logic [3:0] ack_addr_out,
    output logic bypass_ack_out
);
    initial
    begin
        bus_sel_out = 1'b0;
        bus_wr_out = 1'b0;
        bus_size_out = 2'h0;
        bus_addr_out = 32'h0000_0000;
        iack_out = 1'b0;
        ack_addr_out = 4'h0;
        bypass_ack_out = 1'b0;
    end
    // Word at the bit address, half at plus 2, byte at plus 3
    task automatic access(input logic w, input logic [4:0] n, input logic [1:0] sz,
                          output logic [7:0] v);
        @(negedge core_clk_in);
        bus_wr_out = w;
        bus_size_out = sz;
        bus_addr_out = `CSR_BASE_ADDR + {25'h0, n, 2'h0} + {30'h0, |sz, sz[1]};
        bus_sel_out = 1'b1;
        repeat (2) @(negedge core_clk_in);
        v = bus_data_oe_n_in ? 8'hxx : bus_data_in[7:0];
        bus_sel_out = 1'b0;
        // Released lines do not keep the last value
        bus_addr_out = ~bus_addr_out;
        bus_wr_out = ~w;
        @(negedge core_clk_in);
    endtask
    task automatic ack_start(input logic [3:0] a);
        @(negedge core_clk_in);
        ack_addr_out = a;
        iack_out = 1'b1;
    endtask
    // Grant once bypass is requested or 16 cycles pass, dly plus one cycles later
    task automatic ack_grant(input int dly);
        for (int i = 0; i < 16 && bypass_req_in !== 1'b1; i++)
        begin
            @(negedge core_clk_in);
        end
        repeat (dly) @(negedge core_clk_in);
        @(negedge core_clk_in);
        bypass_ack_out = 1'b1;
    endtask
    task automatic ack_end();
        @(negedge core_clk_in);
        iack_out = 1'b0;
        bypass_ack_out = 1'b0;
        ack_addr_out = ~ack_addr_out;
    endtask
endmodule // cpu_bus_model

// *** dv/sys_ctrl_bench.sv ***
/*
 Self-checking bench of the control/status/error register block.
 Assumes the processor bus model and the shared constants header.
*/
`timescale 1ns/10ps
module sys_ctrl_bench;
    typedef struct packed {logic w; logic [4:0] n; logic [1:0] sz; logic [4:0] rn;
                           logic [7:0] e;} row_s;
    logic clk, rstn, sys_rst, pwr_off, reload, vas, sel, wr, iack, gnt, breq, oe_n;
    logic wsel_n, nmi, led, floppy;
    logic [1:0] size;
    logic [31:0] addr, data, events;
    logic [2:0] bub_irq, lines_n, off_ack, bub_ack;
    logic [3:0] ack_a, level;
    logic [7:0] v;
    int num_errors = 0;
    int compares = 0;
    int i;
    logic [3:0] vecs [4] = '{4'hF, 4'hD, 4'hB, 4'h9};
    row_s rows [11] = '{
        '{1'b0, 5'd0, 2'h0, 5'd0, 8'h80},
        '{1'b0, 5'd0, 2'h1, 5'd9, 8'h07},
        '{1'b0, 5'd0, 2'h2, 5'd17, 8'h12},
        '{1'b0, 5'd0, 2'h0, 5'd31, 8'h00},
        '{1'b1, 5'd5, 2'h0, 5'd2, 8'hA0},
        '{1'b1, 5'd6, 2'h1, 5'd7, 8'hE0},
        '{1'b1, 5'd18, 2'h2, 5'd23, 8'h16},
        '{1'b1, 5'd17, 2'h0, 5'd16, 8'h14},
        '{1'b1, 5'd20, 2'h1, 5'd21, 8'h04},
        '{1'b1, 5'd21, 2'h2, 5'd22, 8'h24},
        '{1'b1, 5'd14, 2'h0, 5'd15, 8'h07}};
    sys_ctrl_top #(.SANITY_DIV(10)) sys_ctrl_top_inst (.core_clk_in(clk), .rstn_in(rstn),
        .sys_reset_in(sys_rst), .bus_sel_in(sel), .bus_wr_in(wr), .bus_size_in(size),
        .bus_addr_in(addr), .bus_data_out(data), .bus_data_oe_n_out(oe_n),
        .status_event_in(events), .power_off_in(pwr_off), .sanity_reload_in(reload),
        .vas_in(vas), .bub_irq_in(bub_irq), .floppy_irq_in(floppy),
        .offboard_irq_lines_n_in(lines_n), .iack_in(iack), .ack_addr_in(ack_a),
        .bypass_ack_in(gnt), .bypass_req_out(breq), .offboard_ack_out(off_ack),
        .bub_ack_out(bub_ack), .irq_wait_select_n_out(wsel_n), .irq_level_out(level),
        .nmi_out(nmi), .diag_led_out(led));
    cpu_bus_model cpu_bus_model_inst (.core_clk_in(clk), .bus_data_in(data),
        .bus_data_oe_n_in(oe_n), .bypass_req_in(breq), .bus_sel_out(sel), .bus_wr_out(wr),
        .bus_size_out(size), .bus_addr_out(addr), .iack_out(iack), .ack_addr_out(ack_a),
        .bypass_ack_out(gnt));
    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd_chk(input logic [4:0] rn, input logic [7:0] e);
        cpu_bus_model_inst.access(1'b0, rn, 2'h0, v);
        chk("group", {24'h0, e}, {24'h0, v});
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial
    begin
        rstn = 1'b0;
        sys_rst = 1'b0;
        pwr_off = 1'b0;
        reload = 1'b0;
        vas = 1'b0;
        events = 32'h0000_0000;
        bub_irq = 3'h0;
        floppy = 1'b0;
        lines_n = 3'h7;
        cyc(16);
        chk("oe_n in reset", 32'h1, {31'h0, oe_n});
        chk("nmi in reset", 32'h0, {31'h0, nmi});
        rstn = 1'b1;
        for (i = 0; i < 11; i++)
        begin
            if (rows[i].w)
            begin
                cpu_bus_model_inst.access(1'b1, rows[i].n, rows[i].sz, v);
            end
            cpu_bus_model_inst.access(1'b0, rows[i].rn, rows[i].sz, v);
            chk("group", {24'h0, rows[i].e}, {24'h0, v});
        end
        cyc(3);
        chk("irq level", 32'h9, {28'h0, level});
        floppy = 1'b1;
        cyc(2);
        chk("floppy level", 32'hB, {28'h0, level});
        floppy = 1'b0;
        for (i = 0; i < 4; i++)
        begin
            cpu_bus_model_inst.ack_start(vecs[i]);
            cyc(2);
            chk("vector", {28'h0, vecs[i]}, data);
            chk("wait select", 32'h0, {31'h0, wsel_n});
            cpu_bus_model_inst.ack_end();
            cyc(2);
            chk("wait select end", 32'h1, {31'h0, wsel_n});
        end
        lines_n = 3'b011;
        bub_irq = 3'b001;
        cpu_bus_model_inst.ack_start(4'hE);
        cyc(3);
        chk("early acks", 32'h18, {27'h0, breq, wsel_n, off_ack});
        cpu_bus_model_inst.ack_grant(4);
        cyc(2);
        chk("card ack", 32'h4, {26'h0, bub_ack, off_ack});
        cpu_bus_model_inst.ack_end();
        lines_n = 3'b111;
        bub_irq = 3'b010;
        cyc(2);
        cpu_bus_model_inst.ack_start(4'hC);
        cpu_bus_model_inst.ack_grant(0);
        cyc(2);
        chk("microbus ack", 32'h10, {26'h0, bub_ack, off_ack});
        cpu_bus_model_inst.ack_end();
        bub_irq = 3'b100;
        cyc(2);
        cpu_bus_model_inst.ack_start(4'hA);
        cyc(2);
        cpu_bus_model_inst.ack_end();
        cyc(3);
        chk("aborted ack", 32'h0, {25'h0, breq, bub_ack, off_ack});
        sys_rst = 1'b1;
        cyc(1);
        sys_rst = 1'b0;
        rd_chk(5'd31, 8'h00);
        rd_chk(5'd16, 8'h36);
        rd_chk(5'd3, 8'hE0);
        events[23] = 1'b1;
        cyc(1);
        events[23] = 1'b0;
        rd_chk(5'd20, 8'hB6);
        chk("irq level", 32'hF, {28'h0, level});
        vas = 1'b1;
        pwr_off = 1'b1;
        cyc(8000);
        reload = 1'b1;
        cyc(1);
        reload = 1'b0;
        cyc(4000);
        chk("nmi after reload", 32'h0, {31'h0, nmi});
        for (i = 0; i < 8000 && nmi !== 1'b1; i++)
        begin
            cyc(1);
        end
        chk("nmi and indicator", 32'h3, {30'h0, nmi, led});
        rd_chk(5'd29, 8'h20);
        pwr_off = 1'b0;
        vas = 1'b0;
        cpu_bus_model_inst.access(1'b1, 5'd0, 2'h0, v);
        rd_chk(5'd29, 8'h00);
        rd_chk(5'd0, 8'hE1);
        chk("nmi cleared", 32'h0, {31'h0, nmi});
        events = 32'h0001_8000;
        cyc(1);
        events = 32'h0000_0000;
        cyc(2);
        chk("thermal nmi and led", 32'h3, {30'h0, nmi, led});
        sys_rst = 1'b1;
        cyc(1);
        sys_rst = 1'b0;
        cyc(2);
        chk("thermal cleared", 32'h1, {30'h0, nmi, led});
        complete_run();
    end
endmodule // sys_ctrl_bench

// *** inc/sys_ctrl_consts.svh ***
/*
 Constants of the system control/status/error register, its timers and interrupt logic.
 Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef SYS_CTRL_CONSTS_SVH
`define SYS_CTRL_CONSTS_SVH

`define CSR_BASE_ADDR 32'h0004_4000
`define CSR_SPAN 32'h0000_0080
`define BIT_INTERVAL_TO 0
`define BIT_DUART 3
`define BIT_DUART_DMA 4
`define BIT_PIR9 5
`define BIT_PIR8 6
`define BIT_INH_INTERVAL 7
`define BIT_INH_SANITY 8
`define BIT_INH_BUS 9
`define BIT_FAIL_LED 16
`define BIT_BUS_TO 26
`define BIT_SANITY_TO 29
`define BIT_SYS_RESET_REQ 31
`define CSR_CLR_ON_WRITE 32'h001A_4000
`define CSR_SYSRST_SET 32'h0012_0780
`define CSR_SYSRST_CLR 32'h8000_8000
`define CSR_HW_SET 32'h7F81_801F
`define CSR_BASE_WR_CLEARS 32'h2400_0000
`define CSR_LVL15 32'h2780_0007
`define CSR_NMI 32'h6000_8000
`define CSR_POR_VALUE 32'h0012_0780

`define CORE_CLK_KHZ 100000
`define INTERVAL_BASE_KHZ 100
`define SANITY_BASE_KHZ 10
`define BUS_BASE_KHZ 500
`define BUS_TIMEOUT_US 1000
`define BUS_TIMEOUT_TICKS (`BUS_TIMEOUT_US * `BUS_BASE_KHZ / 1000)
`define INTERVAL_TICKS 1000
`define SANITY_TICKS 1000

`endif

// *** inc/sys_ctrl_pkg.sv ***
/*
 Types of the system control block.
 Assumes nothing beyond the constants header.
*/
package sys_ctrl_pkg;
    typedef enum logic [1:0] {SIZE_WORD = 2'h0, SIZE_HALF = 2'h1, SIZE_BYTE = 2'h2} bus_size_e;
    typedef enum logic [3:0] {
        ACK_IDLE = 4'h1,
        ACK_BYPASS = 4'h2,
        ACK_OFF = 4'h4,
        ACK_ON = 4'h8
    } ack_state_e;
    typedef struct packed {
        logic [31:0] csr;
        logic sel_prev;
        logic [31:0] data;
        logic data_oe_n;
        logic [15:0] ivl_cnt;
        logic [15:0] san_cnt;
        logic [9:0] bus_cnt;
        logic bus_done;
        ack_state_e ack;
        logic [3:0] ack_addr;
        logic [2:0] off_ack;
        logic [2:0] bub_ack;
        logic wsel_n;
        logic bypass_req;
        logic nmi;
    } ctrl_state_s;
endpackage

// *** logic/irq_prio_enc.sv ***
/*
 Registered 8-to-4 priority encoder of interrupt levels 15 down to 8.
 Assumes request bit i stands for level 8+i; output 0 means no request.
*/
`timescale 1ns/10ps
module irq_prio_enc
    import sys_ctrl_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] req_in,
    output logic [3:0] level_out
);
    typedef struct packed {
        logic [3:0] level;
    } enc_state_s;
    enc_state_s q, d;

    always_comb
    begin
        d.level = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (req_in[i])
                d.level = {1'b1, 3'(i)};
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            q <= '0;
        else
            q <= d;
    end

    assign level_out = q.level;
endmodule // irq_prio_enc

// *** logic/sys_ctrl_top.sv ***
/*
 Control/status/error register with interval, sanity and bus timers and interrupt logic.
 Assumes a 100 MHz core clock, a processor bus taken as synchronous, and one access per select.
*/
`timescale 1ns/10ps
`include "sys_ctrl_consts.svh"

// Overview of operation
// - Interval timer counts 100 kHz ticks; held while bit 7 is set.
// - Interval expiry sets bit 0 and requests level 15.
// - Sanity timer counts down at 10 kHz, reloaded by software; held by bit 8.
// - Sanity zero lights diagnostic indicator, requests level 15, sets bit 29.
// - Power switch off starts the sanity countdown.
// - Bus timer counts 500 kHz ticks while address strobe asserted, resets on negation.
// - Bus timer reaching 1 ms lights indicator, requests level 15, sets bit 26.
// - Bus timer held while its inhibit bit (bit 9) is set.
// - A write acts on the decoded address only; data is ignored.
// - A read returns the whole 8-bit group on data 7..0, held all cycle.
// - Hardware reset does not clear the register as a whole.
// - Write at base plus 4n sets bit n; bits 14, 17, 19, 20 clear.
// - System reset sets bits 7-10, 17, 20 and clears 15, 31.
// - Hardware-set bits latch when their sources assert; programmed writes set or clear.
// - Eight levels: three off-board, programmed 9 and 8, three onboard.
// - Active levels priority-encoded and presented as levels 15 to 8.
// - Off-board acknowledge requests bypass, waits for grant, then acknowledges the card.
// - Onboard acknowledge loops address bits 5..2 back as vector, asserts wait select.
// - Enhanced bus peripheral wins over buffered microbus peripheral on same level.
// - Abort, sanity expiry and thermal shutdown raise the nonmaskable interrupt.
// - Level 15 shared by interval, power down, bus, memory, fail, bus timer.
module sys_ctrl_top
    import sys_ctrl_pkg::*;
#(
    parameter int SANITY_DIV = `CORE_CLK_KHZ / `SANITY_BASE_KHZ
)(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic sys_reset_in,
    input wire logic bus_sel_in,
    input wire logic bus_wr_in,
    input wire logic [1:0] bus_size_in,
    input wire logic [31:0] bus_addr_in,
    output logic [31:0] bus_data_out,
    output logic bus_data_oe_n_out,
    input wire logic [31:0] status_event_in,
    input wire logic power_off_in,
    input wire logic sanity_reload_in,
    input wire logic vas_in,
    input wire logic [2:0] bub_irq_in,
    input wire logic floppy_irq_in,
    input wire logic [2:0] offboard_irq_lines_n_in,
    input wire logic iack_in,
    input wire logic [3:0] ack_addr_in,
    input wire logic bypass_ack_in,
    output logic bypass_req_out,
    output logic [2:0] offboard_ack_out,
    output logic [2:0] bub_ack_out,
    output logic irq_wait_select_n_out,
    output logic [3:0] irq_level_out,
    output logic nmi_out,
    output logic diag_led_out
);
    ctrl_state_s q, d;
    logic ivl_tick, san_tick, bus_tick;
    logic [7:0] irq_req;
    logic [31:0] offs;
    logic [4:0] wr_idx;
    logic size_ok, hit, wr_hit, rd_start, clr_bit;
    logic [31:0] clr_mask;
    logic ivl_evt, san_evt, bus_evt;
    logic [1:0] bidx;

    time_base_div #(.DIV(`CORE_CLK_KHZ / `INTERVAL_BASE_KHZ)) u_ivl_div (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_out(ivl_tick)
    );
    time_base_div #(.DIV(SANITY_DIV)) u_san_div (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_out(san_tick)
    );
    time_base_div #(.DIV(`CORE_CLK_KHZ / `BUS_BASE_KHZ)) u_bus_div (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .tick_out(bus_tick)
    );

    // Levels 14, 12, 10 carry both off-board cards and buffered microbus sources
    always_comb
    begin
        irq_req[7] = |(q.csr & `CSR_LVL15);
        irq_req[6] = bub_irq_in[0] | ~offboard_irq_lines_n_in[2];
        irq_req[5] = q.csr[`BIT_DUART] | q.csr[`BIT_DUART_DMA];
        irq_req[4] = bub_irq_in[1] | ~offboard_irq_lines_n_in[1];
        irq_req[3] = floppy_irq_in;
        irq_req[2] = bub_irq_in[2] | ~offboard_irq_lines_n_in[0];
        irq_req[1] = q.csr[`BIT_PIR9];
        irq_req[0] = q.csr[`BIT_PIR8];
    end

    irq_prio_enc u_enc (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .req_in(irq_req),
        .level_out(irq_level_out)
    );

    // Address decode: size must match the low address bits
    always_comb
    begin
        offs = bus_addr_in - `CSR_BASE_ADDR;
        wr_idx = offs[6:2];
        case (bus_size_in)
            SIZE_WORD: size_ok = (offs[1:0] == 2'h0);
            SIZE_HALF: size_ok = (offs[1:0] == 2'h2);
            SIZE_BYTE: size_ok = (offs[1:0] == 2'h3);
            default: size_ok = 1'b0;
        endcase
        hit = (bus_addr_in >= `CSR_BASE_ADDR) && (offs < `CSR_SPAN) && size_ok;
        wr_hit = bus_sel_in && !q.sel_prev && bus_wr_in && hit;
        rd_start = bus_sel_in && !q.sel_prev && !bus_wr_in && hit;
        clr_mask = `CSR_CLR_ON_WRITE;
        clr_bit = clr_mask[wr_idx];
        bidx = 2'(q.ack_addr[2:1] - 2'h1);
    end

    always_comb
    begin
        d = q;
        ivl_evt = 1'b0;
        san_evt = 1'b0;
        bus_evt = 1'b0;
        d.sel_prev = bus_sel_in;

        // Interval timer
        if (q.csr[`BIT_INH_INTERVAL])
            d.ivl_cnt = 16'h0000;
        else if (ivl_tick)
        begin
            if (q.ivl_cnt == 16'(`INTERVAL_TICKS - 1))
            begin
                d.ivl_cnt = 16'h0000;
                ivl_evt = 1'b1;
            end
            else
                d.ivl_cnt = q.ivl_cnt + 16'h0001;
        end

        // Sanity timer: power-off overrides the inhibit
        if (sanity_reload_in)
            d.san_cnt = 16'(`SANITY_TICKS);
        else if (q.csr[`BIT_INH_SANITY] && !power_off_in)
            d.san_cnt = 16'(`SANITY_TICKS);
        else if (san_tick && q.san_cnt != 16'h0000)
        begin
            d.san_cnt = q.san_cnt - 16'h0001;
            san_evt = (q.san_cnt == 16'h0001);
        end

        // Bus access timer
        if (!vas_in || q.csr[`BIT_INH_BUS])
        begin
            d.bus_cnt = 10'h000;
            d.bus_done = 1'b0;
        end
        else if (bus_tick && !q.bus_done)
        begin
            if (q.bus_cnt == 10'(`BUS_TIMEOUT_TICKS - 1))
            begin
                d.bus_done = 1'b1;
                bus_evt = 1'b1;
            end
            else
                d.bus_cnt = q.bus_cnt + 10'h001;
        end

        // Register writes decode only the address
        if (wr_hit)
        begin
            d.csr[wr_idx] = !clr_bit;
            if (wr_idx == 5'h00)
                d.csr = d.csr & ~`CSR_BASE_WR_CLEARS;
        end
        if (sys_reset_in)
            d.csr = (d.csr | `CSR_SYSRST_SET) & ~`CSR_SYSRST_CLR;

        // Hardware sets last so they win over a clear in the same cycle
        d.csr = d.csr | (status_event_in & `CSR_HW_SET);
        if (ivl_evt)
            d.csr[`BIT_INTERVAL_TO] = 1'b1;
        if (san_evt)
        begin
            d.csr[`BIT_SANITY_TO] = 1'b1;
            d.csr[`BIT_FAIL_LED] = 1'b1;
        end
        if (bus_evt)
        begin
            d.csr[`BIT_BUS_TO] = 1'b1;
            d.csr[`BIT_FAIL_LED] = 1'b1;
        end
        d.nmi = |(q.csr & `CSR_NMI);

        // Register read: whole group, held while selected
        if (rd_start)
        begin
            d.data = {24'h00_0000, 8'(q.csr >> {wr_idx[4:3], 3'h0})};
            d.data_oe_n = 1'b0;
        end
        else if (!bus_sel_in && q.ack == ACK_IDLE)
        begin
            d.data = 32'h0000_0000;
            d.data_oe_n = 1'b1;
        end

        // Interrupt acknowledge
        case (q.ack)
            ACK_IDLE:
            begin
                if (iack_in)
                begin
                    d.ack_addr = ack_addr_in;
                    if (!ack_addr_in[0] && (ack_addr_in[1] || ack_addr_in[2]))
                    begin
                        d.ack = ACK_BYPASS;
                        d.bypass_req = 1'b1;
                    end
                    else
                    begin
                        d.ack = ACK_ON;
                        d.data = {28'h000_0000, ack_addr_in};
                        d.data_oe_n = 1'b0;
                        d.wsel_n = 1'b0;
                    end
                end
            end
            ACK_BYPASS:
            begin
                if (!iack_in)
                begin
                    d.ack = ACK_IDLE;
                    d.bypass_req = 1'b0;
                end
                else if (bypass_ack_in)
                begin
                    d.ack = ACK_OFF;
                    if (!offboard_irq_lines_n_in[bidx])
                        d.off_ack[bidx] = 1'b1;
                    else
                        d.bub_ack[bidx] = 1'b1;
                end
            end
            ACK_OFF, ACK_ON:
            begin
                if (!iack_in)
                begin
                    d.ack = ACK_IDLE;
                    d.bypass_req = 1'b0;
                    d.off_ack = 3'h0;
                    d.bub_ack = 3'h0;
                    d.wsel_n = 1'b1;
                    d.data = 32'h0000_0000;
                    d.data_oe_n = 1'b1;
                end
            end
            default:
            begin
                d.ack = ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            q <= '0;
            q.csr <= `CSR_POR_VALUE;
            q.data_oe_n <= 1'b1;
            q.san_cnt <= 16'(`SANITY_TICKS);
            q.ack <= ACK_IDLE;
            q.wsel_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign bus_data_out = q.data;
    assign bus_data_oe_n_out = q.data_oe_n;
    assign bypass_req_out = q.bypass_req;
    assign offboard_ack_out = q.off_ack;
    assign bub_ack_out = q.bub_ack;
    assign irq_wait_select_n_out = q.wsel_n;
    assign nmi_out = q.nmi;
    assign diag_led_out = q.csr[`BIT_FAIL_LED];

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_write_sets_bit: assert property (wr_hit && !sys_reset_in && !clr_bit |=> q.csr[$past(wr_idx)])
        else $error("write did not set its bit");
    a_write_clears_bit: assert property (wr_hit && !sys_reset_in && clr_bit |=> !q.csr[$past(wr_idx)])
        else $error("write did not clear its bit");
    a_sysrst_bits: assert property (sys_reset_in |=> ((q.csr & `CSR_SYSRST_SET) == `CSR_SYSRST_SET) && !q.csr[`BIT_SYS_RESET_REQ])
        else $error("system reset bits wrong");
    a_ivl_inhibit: assert property (q.csr[`BIT_INH_INTERVAL] |=> q.ivl_cnt == 16'h0000)
        else $error("interval timer ran while inhibited");
    a_ivl_expire: assert property (ivl_evt |=> q.csr[`BIT_INTERVAL_TO] ##2 irq_level_out == 4'hF)
        else $error("interval timeout not flagged at level 15");
    a_san_expire: assert property (san_evt |=> q.csr[`BIT_SANITY_TO] && diag_led_out ##1 nmi_out)
        else $error("sanity expiry not flagged");
    a_bus_reset: assert property (!vas_in |=> q.bus_cnt == 10'h000 && !q.bus_done)
        else $error("bus timer not reset");
    a_bus_timeout: assert property (bus_evt |=> q.csr[`BIT_BUS_TO] && diag_led_out)
        else $error("bus timeout not flagged");
    a_read_hold: assert property (rd_start ##1 (bus_sel_in && q.ack == ACK_IDLE) |=> $stable(bus_data_out))
        else $error("read data not held");
    a_onboard_vector: assert property (q.ack == ACK_ON |-> bus_data_out[3:0] == q.ack_addr && !irq_wait_select_n_out)
        else $error("onboard vector wrong");
    a_bypass_first: assert property (q.ack == ACK_BYPASS |-> bypass_req_out && offboard_ack_out == 3'h0 && bub_ack_out == 3'h0)
        else $error("off-board acknowledge before bypass grant");
    a_eio_priority: assert property (q.ack == ACK_BYPASS && iack_in && bypass_ack_in && !offboard_irq_lines_n_in[bidx] |=> offboard_ack_out[$past(bidx)] && bub_ack_out == 3'h0)
        else $error("buffered microbus acknowledged over enhanced bus");
    a_san_inhibit: assert property (q.csr[`BIT_INH_SANITY] && !power_off_in
        |=> q.san_cnt == 16'(`SANITY_TICKS))
        else $error("sanity timer ran while inhibited");
    a_power_off_run: assert property (power_off_in && san_tick && !sanity_reload_in
        && q.san_cnt != 16'h0000 |=> q.san_cnt == $past(q.san_cnt) - 16'h0001)
        else $error("sanity countdown stalled at power off");
    a_bus_inhibit: assert property (q.csr[`BIT_INH_BUS] |=> q.bus_cnt == 10'h000)
        else $error("bus timer ran while inhibited");
    a_level_encode: assert property (irq_req[7] |=> irq_level_out == 4'hF)
        else $error("level 15 not presented");
    a_pir_levels: assert property (irq_req[7:2] == 6'h00 && irq_req[1]
        |=> irq_level_out == 4'h9)
        else $error("programmed level 9 not presented");
    a_nmi_raise: assert property ((|(q.csr & `CSR_NMI)) |=> nmi_out)
        else $error("nonmaskable interrupt missing");
    a_nmi_drop: assert property (!(|(q.csr & `CSR_NMI)) |=> !nmi_out)
        else $error("nonmaskable interrupt without source");
    a_data_idle: assert property (!bus_sel_in && q.ack == ACK_IDLE && !iack_in
        |=> bus_data_oe_n_out)
        else $error("data driven while idle");
    a_hw_set_wins: assert property (status_event_in[`BIT_FAIL_LED] |=> diag_led_out)
        else $error("hardware set of indicator lost");
endmodule // sys_ctrl_top

// *** logic/time_base_div.sv ***
/*
 Divider giving a one-cycle tick every DIV core clocks.
 Assumes one core clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module time_base_div
    import sys_ctrl_pkg::*;
#(
    parameter int DIV = 1000
)(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    output logic tick_out
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_state_s;
    div_state_s q, d;

    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 16'(DIV - 1))
        begin
            d.cnt = 16'h0000;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            q <= '0;
        else
            q <= d;
    end

    assign tick_out = q.tick;
endmodule // time_base_div
